/* File: design/dct_core.sv */
// DRAM-side command path gating, CA parity squash, alert pulses and write leveling echo
// Contract
// - Command path keeps accepting for 4 clocks after power-down entry, then stops.
// - Write leveling returns sampled clock level within 9.5 ns of strobe edge.
// - Parity latency is 4 clocks; commands near a parity error are discarded.
// - Parity alert asserts within parity latency plus 6 ns of errant command.
// - Parity alert stays asserted between 56 and 128 clocks.
// - Write CRC error pulses alert low for 6 to 10 clocks.
// - Alert asserts 3 to 13 ns after a write CRC error is detected.
`timescale 1ns/100ps
`default_nettype none
module dct_core (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic cmd_valid_in,
  input wire logic par_err_in,
  input wire logic crc_err_in,
  input wire logic wl_mode_in,
  input wire logic wl_strobe_in,
  input wire logic ck_level_in,
  output logic cmd_path_on_out,
  output logic cmd_exec_out,
  output logic alert_n_out,
  output logic wl_dq_out,
  output logic wl_dq_oe_out
);
  dct_pkg::dct_pd_t pd_reg;
  dct_pkg::dct_pd_t pd_next;
  logic [2:0] entry_cnt_reg;
  logic path_on_reg;
  logic [dct_pkg::PAR_LAT-2:0] pipe_reg;
  logic [2:0] blank_cnt_reg;
  logic exec_reg;
  logic [7:0] par_cnt_reg;
  logic [7:0] par_cnt_next;
  logic [7:0] crc_cnt_reg;
  logic [7:0] crc_cnt_next;
  logic alert_n_reg;
  logic wl_dq_reg;
  logic wl_dq_oe_reg;
  logic cmd_take;

  function automatic logic [7:0] dct_count_down(input logic [7:0] cnt);
    dct_count_down = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
  endfunction

  // Power-down entry: path stays on while the entry delay runs out
  always_comb begin
    pd_next = pd_reg;
    unique case (pd_reg)
      dct_pkg::DCT_PD_UP: begin
        if (!cke_in) begin
          pd_next = dct_pkg::DCT_PD_ENTRY;
        end
      end
      dct_pkg::DCT_PD_ENTRY: begin
        if (cke_in) begin
          pd_next = dct_pkg::DCT_PD_UP;
        end else if (entry_cnt_reg == 3'h0) begin
          pd_next = dct_pkg::DCT_PD_DOWN;
        end
      end
      dct_pkg::DCT_PD_DOWN: begin
        if (cke_in) begin
          pd_next = dct_pkg::DCT_PD_UP;
        end
      end
      default: pd_next = dct_pkg::DCT_PD_UP;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_reg <= dct_pkg::DCT_PD_UP;
      entry_cnt_reg <= 3'h0;
      path_on_reg <= 1'b1;
    end else begin
      pd_reg <= pd_next;
      if (pd_reg == dct_pkg::DCT_PD_UP) begin
        entry_cnt_reg <= dct_pkg::CPDED_CYC - 3'h1;
      end else if (entry_cnt_reg != 3'h0) begin
        entry_cnt_reg <= entry_cnt_reg - 3'h1;
      end
      path_on_reg <= (pd_next != dct_pkg::DCT_PD_DOWN);
    end
  end

  assign cmd_take = cmd_valid_in && path_on_reg && !par_err_in && (blank_cnt_reg == 3'h0);

  // Commands execute after the parity latency; an error empties the pipe and blanks intake
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pipe_reg <= '0;
      blank_cnt_reg <= 3'h0;
      exec_reg <= 1'b0;
    end else if (par_err_in) begin
      pipe_reg <= '0;
      blank_cnt_reg <= dct_pkg::PAR_LAT_CYC;
      exec_reg <= 1'b0;
    end else begin
      pipe_reg <= {pipe_reg[dct_pkg::PAR_LAT-3:0], cmd_take};
      if (blank_cnt_reg != 3'h0) begin
        blank_cnt_reg <= blank_cnt_reg - 3'h1;
      end
      exec_reg <= pipe_reg[dct_pkg::PAR_LAT-2];
    end
  end

  // Alert pulse widths; a new error restarts its own pulse
  always_comb begin
    par_cnt_next = par_err_in ? dct_pkg::PAR_PW_CYC : dct_count_down(par_cnt_reg);
    crc_cnt_next = crc_err_in ? dct_pkg::CRC_PW_CYC : dct_count_down(crc_cnt_reg);
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_cnt_reg <= 8'h00;
      crc_cnt_reg <= 8'h00;
      alert_n_reg <= 1'b1;
    end else begin
      par_cnt_reg <= par_cnt_next;
      crc_cnt_reg <= crc_cnt_next;
      alert_n_reg <= (par_cnt_next == 8'h00) && (crc_cnt_next == 8'h00);
    end
  end

  // Write leveling: echo the sampled clock level one cycle after the strobe edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wl_dq_reg <= 1'b0;
      wl_dq_oe_reg <= 1'b0;
    end else begin
      wl_dq_oe_reg <= wl_mode_in;
      if (wl_mode_in && wl_strobe_in) begin
        wl_dq_reg <= ck_level_in;
      end
    end
  end

  assign cmd_path_on_out = path_on_reg;
  assign cmd_exec_out = exec_reg;
  assign alert_n_out = alert_n_reg;
  assign wl_dq_out = wl_dq_reg;
  assign wl_dq_oe_out = wl_dq_oe_reg;

  // Length of the current alert-low stretch, for checking pulse widths
  logic [8:0] low_len;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_len <= 9'h000;
    end else if (!alert_n_reg) begin
      low_len <= low_len + 9'h001;
    end else begin
      low_len <= 9'h000;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_path_entry_hold: assert property (
    (pd_reg == dct_pkg::DCT_PD_UP && !cke_in) ##1 (!cke_in)[*4]
      |-> $past(cmd_path_on_out, 4) && $past(cmd_path_on_out, 1) ##1 !cmd_path_on_out)
    else $error("command path closed too early or not at all");
  a_wl_echo: assert property (
    (wl_mode_in && wl_strobe_in) |=> (wl_dq_out == $past(ck_level_in)) && wl_dq_oe_out)
    else $error("write leveling echo wrong");
  a_par_squash: assert property (
    par_err_in |=> !cmd_exec_out[*8])
    else $error("command executed near a parity error");
  a_exec_latency: assert property (
    cmd_exec_out |-> $past(cmd_valid_in, 4) && $past(cmd_path_on_out, 4))
    else $error("command executed without matching intake");
  a_par_alert_on: assert property (
    par_err_in |=> !alert_n_out)
    else $error("parity alert late");
  a_par_alert_width: assert property (
    (par_err_in ##1 !par_err_in[*8]) |-> !alert_n_out[*1] ##0 (low_len <= 9'h080))
    else $error("parity alert stretch too long");
  a_alert_min_width: assert property (
    $rose(alert_n_out) |-> ($past(low_len) >= {1'b0, dct_pkg::CRC_PW_MIN})
      && ($past(low_len) <= {1'b0, dct_pkg::PAR_PW_MAX}))
    else $error("alert pulse width out of range");
  a_crc_pulse: assert property (
    (crc_err_in && par_cnt_reg == 8'h00 && !par_err_in) ##1 (!par_err_in && !crc_err_in)[*8]
      |-> !alert_n_out && !$past(alert_n_out, 7) ##1 alert_n_out)
    else $error("crc alert pulse wrong");

  c_par_alert: cover property (par_err_in ##1 !alert_n_out[*8]);
  c_crc_alert: cover property (crc_err_in ##1 !alert_n_out[*6] ##3 alert_n_out);
  c_power_down: cover property (!cmd_path_on_out ##1 cke_in ##1 cmd_path_on_out);
  c_wl_echo: cover property (wl_mode_in && wl_strobe_in && ck_level_in ##1 wl_dq_out);
endmodule
`default_nettype wire

/* File: pkg/dct_pkg.sv */
// Constants for the DRAM-side command path, parity and alert timing block
package dct_pkg;
  // Clock period at 125 MHz
  localparam int CLK_PERIOD_PS = 8000;
  // Command path disable delay after power-down entry, in clocks
  localparam logic [2:0] CPDED_CYC = 3'h4;
  // Parity latency in clocks
  localparam int PAR_LAT = 4;
  localparam logic [2:0] PAR_LAT_CYC = 3'h4;
  // Extra time allowed for the parity alert beyond the parity latency
  localparam int PAR_ALERT_ON_PS = 6000;
  localparam int PAR_ALERT_ON_CYC =
    (PAR_ALERT_ON_PS / CLK_PERIOD_PS) < 1 ? 1 : (PAR_ALERT_ON_PS / CLK_PERIOD_PS);
  // Parity alert pulse width limits and the width used
  localparam logic [7:0] PAR_PW_MIN = 8'h38;
  localparam logic [7:0] PAR_PW_MAX = 8'h80;
  localparam logic [7:0] PAR_PW_CYC = 8'h40;
  // CRC alert pulse width limits and the width used
  localparam logic [7:0] CRC_PW_MIN = 8'h06;
  localparam logic [7:0] CRC_PW_MAX = 8'h0A;
  localparam logic [7:0] CRC_PW_CYC = 8'h08;
  // CRC error to alert latency window
  localparam int CRC_ALERT_MIN_PS = 3000;
  localparam int CRC_ALERT_MAX_PS = 13000;
  localparam int CRC_ALERT_MIN_CYC = (CRC_ALERT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CRC_ALERT_MAX_CYC =
    (CRC_ALERT_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : (CRC_ALERT_MAX_PS / CLK_PERIOD_PS);
  // Write leveling output delay limit
  localparam int WLO_MAX_PS = 9500;
  localparam int WLO_MAX_CYC =
    (WLO_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : (WLO_MAX_PS / CLK_PERIOD_PS);
  // Power-down states
  typedef enum logic [2:0] {
    DCT_PD_UP    = 3'h1,
    DCT_PD_ENTRY = 3'h2,
    DCT_PD_DOWN  = 3'h4
  } dct_pd_t;
endpackage

/* File: testbench/dct_core_tb.sv */
// Self-checking testbench for the DRAM-side command timing block
`timescale 1ns/100ps
`default_nettype none
module dct_core_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic par_err_in, crc_err_in, wl_mode_in, wl_strobe_in, ck_level_in;
  logic pd_req, cmd_want, rogue, cke_in, cmd_valid_in;
  logic cmd_path_on_out, cmd_exec_out, alert_n_out, wl_dq_out, wl_dq_oe_out;
  logic path_e, exec_e, alert_e, dq_e, oe_e;
  logic [2:0] pipe;
  int blank, lowcnt, pc, cc, cycles, seed, r, fail_count, tests_run, wl_on;
  always #4 clock_in = ~clock_in;
  dct_ctrl_model ctrl_u (.clock_in, .rst_n_in, .alert_n_in(alert_n_out), .pd_req_in(pd_req),
    .cmd_want_in(cmd_want),
    .rogue_in(rogue), .cke_out(cke_in), .cmd_out(cmd_valid_in));
  dct_core dut_u (.clock_in, .rst_n_in, .cke_in, .cmd_valid_in, .par_err_in, .crc_err_in,
    .wl_mode_in, .wl_strobe_in, .ck_level_in, .cmd_path_on_out, .cmd_exec_out,
    .alert_n_out, .wl_dq_out, .wl_dq_oe_out);
  // Reference: values expected to be visible after each rising edge
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {exec_e, dq_e, oe_e, pipe} = '0;
      {path_e, alert_e} = 2'h3;
      blank = 0;
      lowcnt = 0;
      pc = 0;
      cc = 0;
    end else begin
      exec_e = par_err_in ? 1'b0 : pipe[2];
      pipe = par_err_in ? 3'h0 : {pipe[1:0], cmd_valid_in & path_e & blank == 0};
      blank = par_err_in ? 4 : (blank > 0 ? blank - 1 : 0);
      lowcnt = cke_in ? 0 : (lowcnt < 5 ? lowcnt + 1 : 5);
      path_e = lowcnt < 5;
      pc = par_err_in ? 64 : (pc > 0 ? pc - 1 : 0);
      cc = crc_err_in ? 8 : (cc > 0 ? cc - 1 : 0);
      alert_e = pc == 0 && cc == 0;
      if (wl_mode_in && wl_strobe_in) dq_e = ck_level_in;
      oe_e = wl_mode_in;
    end
  end
  task automatic chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: output differs from reference", $time);
    end
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare mid-cycle, then end any one-cycle pulses
  task automatic cyc;
    @(negedge clock_in);
    chk(cmd_path_on_out, path_e);
    chk(cmd_exec_out, exec_e);
    chk(alert_n_out, alert_e);
    chk(wl_dq_out, dq_e);
    chk(wl_dq_oe_out, oe_e);
    {par_err_in, crc_err_in, wl_strobe_in} = 3'h0;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    seed = 34113;
    {par_err_in, crc_err_in, wl_mode_in, wl_strobe_in, ck_level_in} = 5'h00;
    {pd_req, cmd_want, rogue} = 3'h0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    wl_on = 0;
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    cmd_want = 1'b1;
    repeat (8) cyc();
    par_err_in = 1'b1;
    cyc();
    crc_err_in = 1'b1;
    repeat (70) cyc();
    // Short clock-enable drop keeps the path; a long one closes it
    pd_req = 1'b1;
    repeat (27) cyc();
    pd_req = 1'b0;
    repeat (12) cyc();
    pd_req = 1'b1;
    repeat (40) cyc();
    rogue = 1'b1;
    cyc();
    {rogue, pd_req} = 2'h0;
    repeat (12) cyc();
    wl_mode_in = 1'b1;
    repeat (40) cyc();
    for (int i = 0; i < 6; i++) begin
      wl_mode_in = i < 4;
      wl_strobe_in = 1'b1;
      ck_level_in = i[0];
      cyc();
    end
    repeat (4000) begin
      r = $random(seed);
      // Errors only while the alert is idle, so each low stretch belongs to one error cycle
      par_err_in = r[5:0] == 0 && pc == 0 && cc == 0;
      crc_err_in = r[11:6] == 0 && pc == 0 && cc == 0;
      cmd_want = r[12];
      if (r[22:17] == 0) begin
        wl_mode_in = ~wl_mode_in;
        wl_on = 0;
      end else begin
        wl_on++;
      end
      wl_strobe_in = r[13] && (!wl_mode_in || wl_on >= 40);
      ck_level_in = r[14];
      if (r[30:25] == 0) pd_req = ~pd_req;
      cyc();
    end
    close_out();
  end
endmodule
`default_nettype wire

/* File: testbench/dct_ctrl_model.sv */
// Controller-side model that paces clock enable and commands
`timescale 1ns/100ps
`default_nettype none
module dct_ctrl_model #(
  // Idle clocks after the last command before clock enable may drop; plain default
  parameter int PDEN_GAP = 24
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic alert_n_in,
  input wire logic pd_req_in,
  input wire logic cmd_want_in,
  input wire logic rogue_in,
  output logic cke_out,
  output logic cmd_out
);
  int wait_cnt;
  int since_cmd;
  always @(negedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cke_out <= 1'b1;
      wait_cnt <= 0;
      since_cmd <= 0;
    end else begin
      // Gap after the last legal command before power-down entry
      since_cmd <= (cmd_out && !rogue_in) ? 0 : since_cmd + 1;
      if (wait_cnt >= 3 && cke_out == pd_req_in && (!pd_req_in || since_cmd >= PDEN_GAP)) begin
        cke_out <= !pd_req_in;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
  // No mode register sets are sent, so their spacing is never at risk
  // Rogue commands are only sent when a scenario asks for them; alert low means deselects
  assign cmd_out = rogue_in |
    (cmd_want_in & cke_out & !pd_req_in & alert_n_in & wait_cnt >= 4);
endmodule
`default_nettype wire
